//--- rtl/sfdtr_pkg.sv
// Constants and types for the DTR fast-read command block
package sfdtr_pkg;
   // ---------------------------------------------------------------
   // Opcodes and mode bits
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_SINGLE_LINE_DTR_READ = 8'h0d;
   localparam logic [7:0] OP_DUAL_IO_DTR_READ = 8'hbd;
   localparam logic [7:0] OP_QUAD_IO_DTR_READ = 8'hed;
   localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
   // ---------------------------------------------------------------
   // Phase lengths, in edges or clocks of the serial clock
   // ---------------------------------------------------------------
   localparam logic [3:0] DUMMY_SINGLE = 4'h4;
   localparam logic [3:0] DUMMY_DUAL = 4'h2;
   localparam logic [3:0] DUMMY_QUAD = 4'h3;
   localparam logic [4:0] OPC_LAST_SPI = 5'h07;
   localparam logic [4:0] OPC_LAST_QPI = 5'h01;
   localparam logic [4:0] ADDR_LAST_X1 = 5'h17;
   localparam logic [4:0] ADDR_LAST_X2 = 5'h0b;
   localparam logic [4:0] ADDR_LAST_X4 = 5'h05;
   localparam int ADDR_W = 24;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // ---------------------------------------------------------------
   // Register map (byte offsets) and control fields
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_ADDR = 4'h8;
   localparam logic [3:0] REG_DATA = 4'hc;
   localparam int CTRL_WIP = 0;
   localparam int CTRL_QE = 1;
   localparam int CTRL_QPI = 2;
   localparam int CTRL_DCV = 3;
   localparam int CTRL_DC_LSB = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_CMD = 6'b000010,
      ST_ADDR = 6'b000100,
      ST_DUMMY = 6'b001000,
      ST_DATA = 6'b010000,
      ST_REJECT = 6'b100000
   } sfdtr_state_type;
   typedef enum logic [2:0] {
      LANES_X1 = 3'b001,
      LANES_X2 = 3'b010,
      LANES_X4 = 3'b100
   } sfdtr_lanes_type;
endpackage : sfdtr_pkg

//--- rtl/sfdtr_read_engine.sv
// DTR fast-read engine with its read-data FIFO and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Read-data FIFO
// ------------------------------------------------------------------
module sfdtr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] fill_q;
   logic push;
   logic pop;

   assign in_ready = (fill_q != (PW+1)'(DEPTH));
   assign out_valid = (fill_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         fill_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : sfdtr_fifo

// Operation
// R1 - Four-line mode: 0Dh opcode takes two clocks, four bits per clock.
// R2 - Four-line 0Dh: address 8 bits/clock, 3 default dummy clocks, data 8 bits/clock.
// R3 - Four-line 0Dh never enters continuous read mode.
// R4 - Any of these reads is rejected while write in progress is set.
// R5 - Dual read BDh: two bits on each clock edge, address and data.
// R6 - Address starts anywhere, increments per output byte, wraps to zero.
// R7 - Dual read: opcode, address on IO1/IO0, 2 default dummy clocks, data.
// R8 - Mode nibble A enters continuous mode; any other value leaves it.
// R9 - In continuous mode next read starts straight with the address.
// R10 - Host leaves the don't-care mode nibble undriven.
// R11 - Single-line quad read EDh needs the quad enable bit.
// R12 - Quad read: four bits on each clock edge, address and data.
// R13 - Quad read: opcode, address on four lines, 3 default dummies, data.
// R14 - Four-line mode accepts quad read regardless of quad enable.
// R15 - Four-line quad read: two-clock opcode, otherwise as single-line version.
// R16 - Host picks dummy count to suit its clock rate.
// R17 - Single-line DTR read: address two bits/clock on IO0, 4 dummies, data IO1.
// R18 - Configured dummy count is used when valid, else per-command default.
module sfdtr_read_engine (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic flash_cs_n,
   input wire logic flash_sck,
   input wire logic [3:0] flash_io_in,
   output logic [3:0] flash_io_out,
   output logic [3:0] flash_io_oe
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic [3:0] io_s1_q, io_s2_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
      end else begin
         cs_s1_q <= flash_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         sck_s1_q <= flash_sck;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         io_s1_q <= flash_io_in;
         io_s2_q <= io_s1_q;
      end
   end

   logic sck_rise, sck_fall, sck_edge, cs_start;
   assign sck_rise = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
   assign sck_fall = ~sck_s2_q & sck_s3_q & ~cs_s2_q;
   assign sck_edge = sck_rise | sck_fall;
   assign cs_start = ~cs_s2_q & cs_s3_q;

   // ---------------------------------------------------------------
   // Registers and FIFO
   // ---------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic rd_done_q;
   logic write_in_progress_flag, qe, four_line_command_mode;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;
   logic data_sel, ctrl_wr;
   sfdtr_pkg::sfdtr_state_type state_q;
   logic cont_q;
   logic [23:0] addr_q;

   assign write_in_progress_flag = ctrl_q[sfdtr_pkg::CTRL_WIP];
   assign qe = ctrl_q[sfdtr_pkg::CTRL_QE];
   assign four_line_command_mode = ctrl_q[sfdtr_pkg::CTRL_QPI];
   assign data_sel = (avs_address == sfdtr_pkg::REG_DATA);
   assign ctrl_wr = avs_write & (avs_address == sfdtr_pkg::REG_CTRL);
   // A full FIFO stalls the writer instead of dropping bytes
   assign avs_waitrequest = (avs_read & ~rd_done_q) | (avs_write & data_sel & ~fifo_in_ready);

   sfdtr_fifo #(
      .WIDTH(sfdtr_pkg::FIFO_W),
      .DEPTH(sfdtr_pkg::FIFO_D)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(avs_write & data_sel),
      .in_ready(fifo_in_ready),
      .in_data(avs_writedata[7:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= sfdtr_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_done_q <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rd_done_q <= avs_read & ~rd_done_q;
         if (avs_read & ~rd_done_q) begin
            if (avs_address == sfdtr_pkg::REG_CTRL) begin
               avs_readdata <= {24'h0, ctrl_q};
            end else if (avs_address == sfdtr_pkg::REG_STAT) begin
               avs_readdata <= {22'h0, ~fifo_out_valid, ~fifo_in_ready, state_q, cont_q, 1'b0};
            end else if (avs_address == sfdtr_pkg::REG_ADDR) begin
               avs_readdata <= {8'h0, addr_q};
            end else begin
               avs_readdata <= 32'h0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic [23:0] sh_q;
   logic [4:0] cnt_q;
   sfdtr_pkg::sfdtr_lanes_type lanes_q, lanes_n;
   logic ax_q, ax_n, cmd_ok;
   logic [3:0] dflt_q, dflt_n, dummy_n;
   logic [7:0] op_w;
   logic [23:0] take;
   logic [4:0] addr_last, opc_last;
   logic [7:0] mode_q;
   logic [2:0] bcnt_q, units_last;
   logic [7:0] dshift_q;

   assign op_w = four_line_command_mode ? {sh_q[3:0], io_s2_q} : {sh_q[6:0], io_s2_q[0]};
   assign opc_last = four_line_command_mode ? sfdtr_pkg::OPC_LAST_QPI : sfdtr_pkg::OPC_LAST_SPI;  // [R1] [R15]

   always_comb begin
      cmd_ok = 1'b0;
      ax_n = 1'b0;
      lanes_n = sfdtr_pkg::LANES_X4;
      dflt_n = sfdtr_pkg::DUMMY_QUAD;
      if (four_line_command_mode) begin
         if (op_w == sfdtr_pkg::OP_SINGLE_LINE_DTR_READ) begin
            cmd_ok = 1'b1;  // [R2] [R3]
         end else if (op_w == sfdtr_pkg::OP_QUAD_IO_DTR_READ) begin
            cmd_ok = 1'b1;  // [R14] [R15]
            ax_n = 1'b1;
         end
      end else if (op_w == sfdtr_pkg::OP_SINGLE_LINE_DTR_READ) begin
         cmd_ok = 1'b1;  // [R17]
         lanes_n = sfdtr_pkg::LANES_X1;
         dflt_n = sfdtr_pkg::DUMMY_SINGLE;
      end else if (op_w == sfdtr_pkg::OP_DUAL_IO_DTR_READ) begin
         cmd_ok = 1'b1;  // [R5] [R7]
         ax_n = 1'b1;
         lanes_n = sfdtr_pkg::LANES_X2;
         dflt_n = sfdtr_pkg::DUMMY_DUAL;
      end else if (op_w == sfdtr_pkg::OP_QUAD_IO_DTR_READ) begin
         cmd_ok = qe;  // [R11] [R12] [R13]
         ax_n = 1'b1;
      end
   end

   // Configured count wins when marked valid and non-zero
   assign dummy_n = (ctrl_q[sfdtr_pkg::CTRL_DCV] && ctrl_q[7:4] != 4'h0) ?
                    ctrl_q[7:4] : dflt_q;  // [R18] [R16]

   always_comb begin
      case (lanes_q)
         sfdtr_pkg::LANES_X1: begin
            take = {sh_q[22:0], io_s2_q[0]};
            addr_last = sfdtr_pkg::ADDR_LAST_X1;
            units_last = 3'h7;
         end
         sfdtr_pkg::LANES_X2: begin
            take = {sh_q[21:0], io_s2_q[1:0]};
            addr_last = sfdtr_pkg::ADDR_LAST_X2;
            units_last = 3'h3;
         end
         default: begin
            take = {sh_q[19:0], io_s2_q};
            addr_last = sfdtr_pkg::ADDR_LAST_X4;
            units_last = 3'h1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Data unit sequencing
   // ---------------------------------------------------------------
   logic data_go, load, mode_win;
   logic [7:0] src, mode_now;
   // Data starts on the falling edge that ends the last dummy clock
   assign data_go = (state_q == sfdtr_pkg::ST_DUMMY) && sck_fall &&
                    (cnt_q == {dummy_n, 1'b0} - 5'h1);
   // Mode bits fill the first dummy edges; the last one may share an edge with data_go
   assign mode_win = (state_q == sfdtr_pkg::ST_DUMMY) && sck_edge && cnt_q[4:3] == 2'b00 &&
                     cnt_q[2:0] <= units_last;
   assign mode_now = mode_win ? take[7:0] : mode_q;
   assign load = data_go | ((state_q == sfdtr_pkg::ST_DATA) && sck_edge && bcnt_q == 3'h0);
   assign fifo_pop = load & fifo_out_valid;
   // An empty FIFO reads as erased array rather than stalling the host
   assign src = load ? (fifo_out_valid ? fifo_out_data : sfdtr_pkg::ERASED_BYTE) : dshift_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= sfdtr_pkg::ST_IDLE;
         cnt_q <= 5'h0;
         sh_q <= 24'h0;
         lanes_q <= sfdtr_pkg::LANES_X1;
         ax_q <= 1'b0;
         dflt_q <= sfdtr_pkg::DUMMY_SINGLE;
         mode_q <= 8'h0;
      end else if (cs_s2_q) begin
         state_q <= sfdtr_pkg::ST_IDLE;
         cnt_q <= 5'h0;
      end else begin
         case (state_q)
            sfdtr_pkg::ST_IDLE: begin
               if (cs_start) begin
                  cnt_q <= 5'h0;
                  sh_q <= 24'h0;
                  if (cont_q) begin
                     state_q <= write_in_progress_flag ? sfdtr_pkg::ST_REJECT : sfdtr_pkg::ST_ADDR;  // [R9] [R4]
                  end else begin
                     state_q <= sfdtr_pkg::ST_CMD;
                  end
               end
            end
            sfdtr_pkg::ST_CMD: begin
               if (sck_rise) begin
                  sh_q <= {16'h0, op_w};
                  cnt_q <= cnt_q + 5'h1;
                  if (cnt_q == opc_last) begin
                     cnt_q <= 5'h0;
                     if (cmd_ok && !write_in_progress_flag) begin
                        state_q <= sfdtr_pkg::ST_ADDR;
                        lanes_q <= lanes_n;
                        ax_q <= ax_n;
                        dflt_q <= dflt_n;
                     end else begin
                        state_q <= sfdtr_pkg::ST_REJECT;  // [R4]
                     end
                  end
               end
            end
            sfdtr_pkg::ST_ADDR: begin
               // Address begins on a rising edge, then takes both edges
               if (sck_rise || (sck_fall && cnt_q != 5'h0)) begin
                  sh_q <= take;
                  cnt_q <= cnt_q + 5'h1;
                  if (cnt_q == addr_last) begin
                     cnt_q <= 5'h0;
                     state_q <= sfdtr_pkg::ST_DUMMY;
                  end
               end
            end
            sfdtr_pkg::ST_DUMMY: begin
               if (sck_edge) begin
                  cnt_q <= cnt_q + 5'h1;
                  if (mode_win) begin
                     sh_q <= take;
                     mode_q <= take[7:0];
                  end
                  if (data_go) begin
                     state_q <= sfdtr_pkg::ST_DATA;
                  end
               end
            end
            sfdtr_pkg::ST_DATA: begin
            end
            default: begin
            end
         endcase
      end
   end

   // Mode byte is the first 8 bits gathered in the dummy phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cont_q <= 1'b0;
      end else if (data_go) begin
         cont_q <= ax_q && (mode_now[7:4] == sfdtr_pkg::CONT_MODE_NIBBLE);  // [R8] [R3] [R10]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_q <= 24'h0;
         dshift_q <= 8'h0;
         bcnt_q <= 3'h0;
         flash_io_out <= 4'h0;
         flash_io_oe <= 4'h0;
      end else begin
         if (state_q == sfdtr_pkg::ST_ADDR && sck_edge && cnt_q == addr_last) begin
            addr_q <= take;  // [R6]
         end else if (state_q == sfdtr_pkg::ST_DATA && sck_edge && !load &&
                      bcnt_q == 3'h1) begin
            addr_q <= addr_q + 24'h1;  // [R6]
         end
         if (load || (state_q == sfdtr_pkg::ST_DATA && sck_edge)) begin
            bcnt_q <= load ? units_last : bcnt_q - 3'h1;
            case (lanes_q)
               sfdtr_pkg::LANES_X1: begin
                  flash_io_out <= {2'b0, src[7], 1'b0};  // [R17]
                  dshift_q <= {src[6:0], 1'b0};
                  flash_io_oe <= 4'b0010;
               end
               sfdtr_pkg::LANES_X2: begin
                  flash_io_out <= {2'b0, src[7:6]};  // [R5]
                  dshift_q <= {src[5:0], 2'b0};
                  flash_io_oe <= 4'b0011;
               end
               default: begin
                  flash_io_out <= src[7:4];  // [R12] [R2]
                  dshift_q <= {src[3:0], 4'h0};
                  flash_io_oe <= 4'b1111;
               end
            endcase
         end else if (state_q != sfdtr_pkg::ST_DATA) begin
            flash_io_oe <= 4'h0;
         end
      end
   end
endmodule : sfdtr_read_engine

`default_nettype wire

//--- verif/sfdtr_read_engine_props.sv
// Port-level assertions for the DTR read engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module sfdtr_read_engine_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic flash_cs_n,
   input wire logic flash_sck,
   input wire logic [3:0] flash_io_in,
   input wire logic [3:0] flash_io_out,
   input wire logic [3:0] flash_io_oe
);
   logic wip_q;
   logic cs_n_q;
   logic wip_frame_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Shadow of the busy flag, frozen when a frame starts
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wip_q <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == sfdtr_pkg::REG_CTRL) begin
         wip_q <= avs_writedata[sfdtr_pkg::CTRL_WIP];
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_n_q <= 1'b1;
         wip_frame_q <= 1'b0;
      end else begin
         cs_n_q <= flash_cs_n;
         if (cs_n_q && !flash_cs_n) begin
            wip_frame_q <= wip_q;
         end
      end
   end
   chk_read_first_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
      else $error("read answered without a wait cycle");
   chk_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read wait longer than one cycle");
   chk_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   chk_reg_write_now: assert property (avs_write && avs_address != sfdtr_pkg::REG_DATA
      |-> !avs_waitrequest) else $error("register write stalled");
   chk_blank_read_zero: assert property (avs_read && !avs_waitrequest &&
      (avs_address[1:0] != 2'h0 || avs_address == sfdtr_pkg::REG_DATA) |-> avs_readdata == 32'h0)
      else $error("unmapped or data read not zero");
   chk_state_onehot: assert property (avs_read && !avs_waitrequest &&
      avs_address == sfdtr_pkg::REG_STAT |-> $onehot(avs_readdata[7:2]))
      else $error("state field not one-hot");
   chk_oe_release: assert property (flash_cs_n [*6] |-> flash_io_oe == 4'h0)
      else $error("lines driven while deselected");
   chk_busy_silent: assert property (!flash_cs_n && wip_frame_q |-> flash_io_oe == 4'h0)
      else $error("lines driven during a busy frame");
   chk_oe_lane_set: assert property (flash_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal output lane set");
endmodule : sfdtr_read_engine_chk
bind sfdtr_read_engine sfdtr_read_engine_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .flash_cs_n(flash_cs_n), .flash_sck(flash_sck),
   .flash_io_in(flash_io_in), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe));
`default_nettype wire

//--- verif/sfdtr_host_model.sv
// Host controller model that issues DTR read frames on the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfdtr_host_model (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   logic [3:0] io_q = 4'h0;
   logic [3:0] mask_q = 4'h0;
   logic [7:0] rx_q[$];
   int n_drive = 0;
   int n_clash = 0;
   initial cs_n = 1'b1;
   initial sck = 1'b0;
   // Released lanes flip every half clock so a stale value never reads as valid
   assign io_in = (io_oe & io_out) | (~io_oe & io_q);
   always @(posedge clk) begin
      if (!cs_n && io_oe != 4'h0) n_drive++;
      if ((io_oe & mask_q) != 4'h0) n_clash++;
   end
   // ----------------------------------------------------------------
   // One serial half clock: 4 system clocks, 160 ns per serial period
   // ----------------------------------------------------------------
   task automatic half(input logic [3:0] m, input logic [3:0] v, output logic [3:0] s);
      @(posedge clk);
      mask_q <= m;
      io_q <= (v & m) | (~io_q & ~m);
      repeat (2) @(posedge clk);
      s = io_in;
      sck <= ~sck;
      @(posedge clk);
   endtask : half
   task automatic frame(input logic four_line_command_mode, input logic [7:0] op, input logic skip,
         input logic [23:0] adr, input int ln, input int dum, input int mode, input int nb);
      int k;
      logic [3:0] s;
      logic [3:0] m;
      logic [7:0] sh;
      logic [7:0] mb;
      m = 4'((1 << ln) - 1);
      mb = mode[7:0];
      sh = 8'h00;
      rx_q.delete();
      n_drive = 0;
      @(posedge clk);
      cs_n <= 1'b0;
      // Opcode is taken on rising edges only, so both halves carry it
      for (k = 0; k < (skip ? 0 : (four_line_command_mode ? 4 : 16)); k++) begin
         half(four_line_command_mode ? 4'hf : 4'h1, four_line_command_mode ? op[7 - 4 * (k / 2) -: 4] : {3'h0, op[7 - k / 2]}, s);
      end
      for (k = 0; k < 24 / ln; k++) begin
         half(m, adr[23 -: 4] >> (4 - ln), s);
         adr = adr << ln;
      end
      // Only the mode nibble is driven; its don't-care half is released
      for (k = 0; k < 2 * dum; k++) begin
         half((mode >= 0 && k < 4 / ln) ? m : 4'h0, mb[7 -: 4] >> (4 - ln), s);
         mb = mb << ln;
      end
      for (k = 0; k < nb * 8 / ln; k++) begin
         half(4'h0, 4'h0, s);
         sh = (ln == 4) ? {sh[3:0], s} : (ln == 2) ? {sh[5:0], s[1:0]} : {sh[6:0], s[1]};
         if ((k + 1) % (8 / ln) == 0) rx_q.push_back(sh);
      end
      @(posedge clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : frame
endmodule : sfdtr_host_model
`default_nettype wire

//--- verif/tb_sfdtr_read_engine.sv
// Self-checking bench for the DTR read engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_sfdtr_read_engine;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   wire logic flash_cs_n;
   wire logic flash_sck;
   wire logic [3:0] flash_io_in;
   logic [3:0] flash_io_out;
   logic [3:0] flash_io_oe;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   int n_wait = 0;
   logic [31:0] rd;
   logic [7:0] exp_q[$];
   always #10 clk = ~clk;
   sfdtr_read_engine u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_cs_n(flash_cs_n),
      .flash_sck(flash_sck), .flash_io_in(flash_io_in), .flash_io_out(flash_io_out),
      .flash_io_oe(flash_io_oe));
   sfdtr_host_model u_host (.clk(clk), .cs_n(flash_cs_n), .sck(flash_sck),
      .io_in(flash_io_in), .io_out(flash_io_out), .io_oe(flash_io_oe));
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n_wait = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         n_wait++;
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task automatic rg(input logic [3:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rg
   task automatic push(input logic [7:0] b[$]);
      foreach (b[i]) av(1'b1, 4'hc, {24'h0, b[i]});
   endtask : push
   task automatic chk_rx(input logic [7:0] e[$]);
      foreach (e[i]) `CHK(u_host.rx_q[i], e[i])
   endtask : chk_rx
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // Generous ceiling: the whole sequence needs about 1700 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rg(4'h0, 32'h0);
      rg(4'h4, 32'h204);
      av(1'b1, 4'h2, 32'hff);
      rg(4'h2, 32'h0);
      rg(4'h0, 32'h0);
      $display("test registers done");
      av(1'b1, 4'h0, 32'h2);
      push('{8'ha5, 8'h5a, 8'hc3});
      u_host.frame(1'b0, sfdtr_pkg::OP_QUAD_IO_DTR_READ, 1'b0, 24'hffffff, 4, 3, 'ha0, 4);
      chk_rx('{8'ha5, 8'h5a, 8'hc3, 8'hff});
      rg(4'h8, 32'h3);
      rg(4'h4, 32'h206);
      push('{8'h3c});
      u_host.frame(1'b0, 8'h00, 1'b1, 24'h000100, 4, 3, 'h00, 1);
      chk_rx('{8'h3c});
      rg(4'h4, 32'h204);
      $display("test quad done");
      push('{8'h81, 8'h7e});
      u_host.frame(1'b0, sfdtr_pkg::OP_DUAL_IO_DTR_READ, 1'b0, 24'h000020, 2, 2, 'ha5, 2);
      chk_rx('{8'h81, 8'h7e});
      rg(4'h4, 32'h206);
      u_host.frame(1'b0, 8'h00, 1'b1, 24'h000040, 2, 2, 'h00, 0);
      rg(4'h4, 32'h204);
      push('{8'h96, 8'h69});
      u_host.frame(1'b0, sfdtr_pkg::OP_SINGLE_LINE_DTR_READ, 1'b0, 24'h123456, 1, 4, -1, 2);
      chk_rx('{8'h96, 8'h69});
      rg(4'h8, 32'h123458);
      $display("test dual and single done");
      av(1'b1, 4'h0, 32'h0);
      push('{8'h11});
      u_host.frame(1'b0, sfdtr_pkg::OP_QUAD_IO_DTR_READ, 1'b0, 24'h0, 4, 3, 'h00, 1);
      `CHK(u_host.n_drive == 0, 1'b1)
      av(1'b1, 4'h0, 32'h3);
      u_host.frame(1'b0, sfdtr_pkg::OP_DUAL_IO_DTR_READ, 1'b0, 24'h0, 2, 2, 'h00, 1);
      `CHK(u_host.n_drive == 0, 1'b1)
      rg(4'h4, 32'h004);
      $display("test refusals done");
      av(1'b1, 4'h0, 32'h4);
      u_host.frame(1'b1, sfdtr_pkg::OP_SINGLE_LINE_DTR_READ, 1'b0, 24'h0000ff, 4, 3, 'ha0, 2);
      chk_rx('{8'h11, 8'hff});
      rg(4'h4, 32'h204);
      av(1'b1, 4'h0, 32'h5c);
      push('{8'h77});
      u_host.frame(1'b1, sfdtr_pkg::OP_QUAD_IO_DTR_READ, 1'b0, 24'h000200, 4, 5, 'ha0, 1);
      chk_rx('{8'h77});
      rg(4'h4, 32'h206);
      $display("test four-line done");
      exp_q.delete();
      for (int i = 0; i < 32; i++) begin
         av(1'b1, 4'hc, 32'(i));
         exp_q.push_back(8'(i));
      end
      exp_q.push_back(8'he0);
      exp_q.push_back(8'hff);
      rg(4'h4, 32'h106);
      fork
         av(1'b1, 4'hc, 32'he0);
         u_host.frame(1'b1, 8'h00, 1'b1, 24'h0, 4, 5, 'h00, 34);
      join
      `CHK(n_wait != 0, 1'b1)
      chk_rx(exp_q);
      `CHK(u_host.n_clash == 0, 1'b1)
      $display("test buffer done");
      close_out();
   end
endmodule : tb_sfdtr_read_engine
`default_nettype wire
